/* File: rtl/iyr_pkg.sv */
// Package for the Y-indexed and relative bus sequencer.
// Assumes one clock domain; shared by the sequencer and its bench.
package iyr_pkg;
    localparam logic [7:0] IYR_PREBYTE = 8'h18;
    localparam logic [15:0] IYR_DUMMY_ADDR = 16'hFFFF;
    localparam logic [15:0] IYR_RESET_SP = 16'h00FF;
    localparam logic [15:0] IYR_RESET_IY = 16'h0000;
    localparam logic [15:0] IYR_RESET_PC = 16'h0000;
    localparam logic [7:0] IYR_RESET_ACC = 8'h00;
    localparam logic [15:0] IYR_RESET_REG = 16'h0000;
    localparam logic [3:0] IYR_CYC_JMP = 4'h4;
    localparam logic [3:0] IYR_CYC_RD8 = 4'h5;
    localparam logic [3:0] IYR_CYC_RMW = 4'h7;
    localparam logic [3:0] IYR_CYC_TST = 4'h7;
    localparam logic [3:0] IYR_CYC_ST8 = 4'h5;
    localparam logic [3:0] IYR_CYC_LD16 = 4'h6;
    localparam logic [3:0] IYR_CYC_ST16 = 4'h6;
    localparam logic [3:0] IYR_CYC_AR16 = 4'h7;
    localparam logic [3:0] IYR_CYC_JSR = 4'h7;
    localparam logic [3:0] IYR_CYC_BIT = 4'h8;
    localparam logic [3:0] IYR_CYC_BRB = 4'h8;
    localparam logic [3:0] IYR_CYC_BR = 4'h3;
    localparam logic [3:0] IYR_CYC_BSR = 4'h6;

    // Instruction groups; selected by the caller, not decoded from opcodes
    typedef enum logic [3:0] {
        IYR_G_JMP, IYR_G_RD8, IYR_G_RMW, IYR_G_TST, IYR_G_ST8,
        IYR_G_LD16, IYR_G_ST16, IYR_G_AR16, IYR_G_JSR, IYR_G_BIT,
        IYR_G_BRB, IYR_G_BR, IYR_G_BSR
    } iyr_group_e;

    // Data-bus content of a cycle
    typedef enum logic [2:0] {
        IYR_K_OPCODE, IYR_K_OFFSET, IYR_K_OPERAND, IYR_K_DUMMY,
        IYR_K_STACK, IYR_K_MASK, IYR_K_IDLE
    } iyr_kind_e;
endpackage

/* File: rtl/iyr_sequencer.sv */
// Bus sequencer for Y-indexed and relative instruction groups.
// Assumes memory answers every read in the same cycle on rd_data.
// Contract
// - Y-indexed fetch: prebyte, second opcode, then offset at successive addresses.
// - After the offset, one dummy read at all-ones address, data ignored.
// - Effective address is Y plus unsigned offset; second byte at plus one.
// - Y-indexed jump takes 4 read cycles with no operand access.
// - Y-indexed 8-bit reads take 5 cycles, operand read last.
// - Y-indexed read-modify-write takes 7 cycles, dummy read, then write back.
// - Y-indexed test takes 7 cycles, one operand read, two dummies.
// - Y-indexed 8-bit store takes 5 cycles, writing accumulator last.
// - Y-indexed 16-bit load takes 6 cycles, high byte then low byte.
// - Y-indexed 16-bit store takes 6 cycles, writing high then low.
// - Y-indexed 16-bit arithmetic takes 7 cycles, two reads, one dummy.
// - Y-indexed call takes 7 cycles, target opcode read in cycle five.
// - Calls write return low byte at SP, high byte at SP minus one.
// - Bit set/clear takes 8 cycles: operand, mask, dummy, write back.
// - Bit test branch takes 8 cycles: operand, mask, offset, dummy.
// - Relative branches take 3 cycles: opcode, offset, dummy read.
// - Relative call takes 6 cycles: offset, dummy, target opcode, stacking.
// - Relative call stacks at SP, then SP minus one.
`timescale 1ns/1ps
`default_nettype none
module iyr_sequencer
    import iyr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Instruction request
    input wire logic start,
    input wire iyr_group_e group,
    input wire logic [15:0] opcode_addr,
    input wire logic [7:0] modify_data,
    input wire logic [7:0] acc_data,
    input wire logic [15:0] store_data,
    input wire logic load_y,
    // Memory bus
    input wire logic [7:0] rd_data,
    output logic [15:0] addr,
    output logic rw,
    output logic [7:0] wr_data,
    output logic bus_valid,
    output iyr_kind_e data_kind,
    // Status
    output logic busy,
    output logic done,
    output logic [3:0] cycle_num,
    output logic [15:0] index_y_register,
    output logic [15:0] stack_ptr,
    output logic [15:0] eff_addr,
    output logic [15:0] operand,
    output logic [7:0] mask_byte,
    output logic [7:0] branch_offset
);
    iyr_group_e grp_r;
    logic [3:0] cnt_r;
    logic [15:0] pc_r;
    logic [7:0] mod_r;
    logic [7:0] acc_r;
    logic [15:0] st_r;
    logic ldy_r;

    function automatic logic [3:0] cycles_of(input iyr_group_e g);
        case (g)
            IYR_G_JMP: cycles_of = IYR_CYC_JMP;
            IYR_G_RD8: cycles_of = IYR_CYC_RD8;
            IYR_G_RMW: cycles_of = IYR_CYC_RMW;
            IYR_G_TST: cycles_of = IYR_CYC_TST;
            IYR_G_ST8: cycles_of = IYR_CYC_ST8;
            IYR_G_LD16: cycles_of = IYR_CYC_LD16;
            IYR_G_ST16: cycles_of = IYR_CYC_ST16;
            IYR_G_AR16: cycles_of = IYR_CYC_AR16;
            IYR_G_JSR: cycles_of = IYR_CYC_JSR;
            IYR_G_BIT: cycles_of = IYR_CYC_BIT;
            IYR_G_BRB: cycles_of = IYR_CYC_BRB;
            IYR_G_BR: cycles_of = IYR_CYC_BR;
            IYR_G_BSR: cycles_of = IYR_CYC_BSR;
            default: cycles_of = IYR_CYC_BR;
        endcase
    endfunction

    function automatic logic is_rel(input iyr_group_e g);
        is_rel = (g == IYR_G_BR) || (g == IYR_G_BSR);
    endfunction

    // Combinational plan of cycle n (1-based) for the current group
    logic [15:0] a_nxt;
    logic rw_nxt;
    logic [7:0] wd_nxt;
    iyr_kind_e k_nxt;
    logic [15:0] ea;
    logic [15:0] ret;
    logic [7:0] rd_offset_r;
    logic last;
    assign last = busy && (cnt_r == cycles_of(grp_r));

    always_comb begin
        ea = index_y_register + {8'h00, rd_offset_r};
        ret = is_rel(grp_r) ? pc_r + 16'h0002 : pc_r + 16'h0003;
        a_nxt = IYR_DUMMY_ADDR;
        rw_nxt = 1'b1;
        wd_nxt = 8'h00;
        k_nxt = IYR_K_DUMMY;
        if (is_rel(grp_r)) begin
            case (cnt_r)
                4'h1: begin
                    a_nxt = pc_r;
                    k_nxt = IYR_K_OPCODE;
                end
                4'h2: begin
                    a_nxt = pc_r + 16'h0001;
                    k_nxt = IYR_K_OFFSET;
                end
                4'h3: k_nxt = IYR_K_DUMMY;
                4'h4: begin
                    a_nxt = pc_r + 16'h0002
                        + {{8{rd_offset_r[7]}}, rd_offset_r};
                    k_nxt = IYR_K_OPCODE;
                end
                4'h5: begin
                    a_nxt = stack_ptr;
                    rw_nxt = 1'b0;
                    wd_nxt = ret[7:0];
                    k_nxt = IYR_K_STACK;
                end
                4'h6: begin
                    a_nxt = stack_ptr - 16'h0001;
                    rw_nxt = 1'b0;
                    wd_nxt = ret[15:8];
                    k_nxt = IYR_K_STACK;
                end
                default: k_nxt = IYR_K_DUMMY;
            endcase
        end else begin
            case (cnt_r)
                4'h1: begin
                    a_nxt = pc_r;
                    k_nxt = IYR_K_OPCODE;
                end
                4'h2: begin
                    a_nxt = pc_r + 16'h0001;
                    k_nxt = IYR_K_OPCODE;
                end
                4'h3: begin
                    a_nxt = pc_r + 16'h0002;
                    k_nxt = IYR_K_OFFSET;
                end
                4'h4: k_nxt = IYR_K_DUMMY;
                4'h5: begin
                    // eff_addr loads on this very edge, so use the sum
                    a_nxt = ea;
                    k_nxt = (grp_r == IYR_G_JSR) ? IYR_K_OPCODE
                        : IYR_K_OPERAND;
                    if (grp_r == IYR_G_ST8) begin
                        rw_nxt = 1'b0;
                        wd_nxt = acc_r;
                    end else if (grp_r == IYR_G_ST16) begin
                        rw_nxt = 1'b0;
                        wd_nxt = st_r[15:8];
                    end
                end
                4'h6: begin
                    case (grp_r)
                        IYR_G_RMW, IYR_G_TST: k_nxt = IYR_K_DUMMY;
                        IYR_G_LD16, IYR_G_AR16: begin
                            a_nxt = eff_addr + 16'h0001;
                            k_nxt = IYR_K_OPERAND;
                        end
                        IYR_G_ST16: begin
                            a_nxt = eff_addr + 16'h0001;
                            rw_nxt = 1'b0;
                            wd_nxt = st_r[7:0];
                            k_nxt = IYR_K_OPERAND;
                        end
                        IYR_G_JSR: begin
                            a_nxt = stack_ptr;
                            rw_nxt = 1'b0;
                            wd_nxt = ret[7:0];
                            k_nxt = IYR_K_STACK;
                        end
                        IYR_G_BIT, IYR_G_BRB: begin
                            a_nxt = pc_r + 16'h0003;
                            k_nxt = IYR_K_MASK;
                        end
                        default: k_nxt = IYR_K_DUMMY;
                    endcase
                end
                4'h7: begin
                    case (grp_r)
                        IYR_G_RMW: begin
                            a_nxt = eff_addr;
                            rw_nxt = 1'b0;
                            wd_nxt = mod_r;
                            k_nxt = IYR_K_OPERAND;
                        end
                        IYR_G_JSR: begin
                            a_nxt = stack_ptr - 16'h0001;
                            rw_nxt = 1'b0;
                            wd_nxt = ret[15:8];
                            k_nxt = IYR_K_STACK;
                        end
                        IYR_G_BRB: begin
                            a_nxt = pc_r + 16'h0004;
                            k_nxt = IYR_K_OFFSET;
                        end
                        default: k_nxt = IYR_K_DUMMY;
                    endcase
                end
                4'h8: begin
                    if (grp_r == IYR_G_BIT) begin
                        a_nxt = eff_addr;
                        rw_nxt = 1'b0;
                        wd_nxt = mod_r;
                        k_nxt = IYR_K_OPERAND;
                    end
                end
                default: k_nxt = IYR_K_DUMMY;
            endcase
        end
    end

    // Sequencing; a start while busy is ignored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            cnt_r <= 4'h0;
            grp_r <= IYR_G_BR;
            pc_r <= IYR_RESET_PC;
            mod_r <= IYR_RESET_ACC;
            acc_r <= IYR_RESET_ACC;
            st_r <= IYR_RESET_REG;
            ldy_r <= 1'b0;
        end else if (!busy) begin
            if (start) begin
                busy <= 1'b1;
                cnt_r <= 4'h1;
                grp_r <= group;
                pc_r <= opcode_addr;
                mod_r <= modify_data;
                acc_r <= acc_data;
                st_r <= store_data;
                ldy_r <= load_y;
            end
        end else if (last) begin
            busy <= 1'b0;
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // Registered bus outputs for the current cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr <= IYR_DUMMY_ADDR;
            rw <= 1'b1;
            wr_data <= 8'h00;
            bus_valid <= 1'b0;
            data_kind <= IYR_K_IDLE;
            cycle_num <= 4'h0;
        end else begin
            addr <= busy ? a_nxt : IYR_DUMMY_ADDR;
            rw <= busy ? rw_nxt : 1'b1;
            wr_data <= busy ? wd_nxt : 8'h00;
            bus_valid <= busy;
            data_kind <= busy ? k_nxt : IYR_K_IDLE;
            cycle_num <= busy ? cnt_r : 4'h0;
        end
    end

    // Captures from the data bus, on the clock edge that ends the bus cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_offset_r <= 8'h00;
            eff_addr <= IYR_RESET_REG;
            operand <= IYR_RESET_REG;
            mask_byte <= 8'h00;
            branch_offset <= 8'h00;
            index_y_register <= IYR_RESET_IY;
            done <= 1'b0;
        end else begin
            done <= bus_valid && cycle_num == cycles_of(grp_r) && !busy;
            if (bus_valid && data_kind == IYR_K_OFFSET && cycle_num <= 4'h3)
            begin
                rd_offset_r <= rd_data;
                branch_offset <= rd_data;
            end
            if (bus_valid && cycle_num == 4'h4 && !is_rel(grp_r))
                eff_addr <= ea;
            if (bus_valid && rw && data_kind == IYR_K_OPERAND) begin
                if (cycle_num == 4'h5)
                    operand <= {rd_data, 8'h00};
                else
                    operand <= {operand[15:8], rd_data};
            end
            if (bus_valid && data_kind == IYR_K_MASK)
                mask_byte <= rd_data;
            if (bus_valid && data_kind == IYR_K_OFFSET && cycle_num == 4'h7)
                branch_offset <= rd_data;
            if (bus_valid && grp_r == IYR_G_LD16 && ldy_r
                && cycle_num == 4'h6)
                index_y_register <= {operand[15:8], rd_data};
        end
    end

    // Stack pointer drops by two at the last stacking write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_ptr <= IYR_RESET_SP;
        end else if (busy && !rw_nxt && k_nxt == IYR_K_STACK && last) begin
            stack_ptr <= stack_ptr - 16'h0002;
        end
    end

    property p_dummy_after_offset;
        @(posedge clk) disable iff (!reset_n)
        (bus_valid && cycle_num == 4'h3 && !is_rel(grp_r))
            |=> (addr == IYR_DUMMY_ADDR && rw);
    endproperty
    a_dummy_after_offset: assert property (p_dummy_after_offset)
        else $error("no dummy read after offset");

    property p_prebyte_first;
        @(posedge clk) disable iff (!reset_n)
        (bus_valid && cycle_num == 4'h1 && !is_rel(grp_r))
            |=> (addr == $past(addr) + 16'h0001)
            ##1 (addr == $past(addr, 2) + 16'h0002);
    endproperty
    a_prebyte_first: assert property (p_prebyte_first)
        else $error("prefix fetch addresses wrong");

    property p_branch_len;
        @(posedge clk) disable iff (!reset_n)
        (bus_valid && cycle_num == 4'h1 && grp_r == IYR_G_BR)
            |=> ##1 (addr == IYR_DUMMY_ADDR) ##1 !bus_valid;
    endproperty
    a_branch_len: assert property (p_branch_len)
        else $error("branch not three cycles");

    property p_jmp_reads;
        @(posedge clk) disable iff (!reset_n)
        (bus_valid && grp_r == IYR_G_JMP) |-> rw;
    endproperty
    a_jmp_reads: assert property (p_jmp_reads)
        else $error("jump wrote the bus");

    property p_st8_write;
        @(posedge clk) disable iff (!reset_n)
        (bus_valid && grp_r == IYR_G_ST8) |-> (rw == (cycle_num != 4'h5));
    endproperty
    a_st8_write: assert property (p_st8_write)
        else $error("byte store write misplaced");

    property p_tst_no_write;
        @(posedge clk) disable iff (!reset_n)
        (bus_valid && (grp_r == IYR_G_TST || grp_r == IYR_G_BRB)) |-> rw;
    endproperty
    a_tst_no_write: assert property (p_tst_no_write)
        else $error("test wrote the bus");

    property p_stack_pair;
        @(posedge clk) disable iff (!reset_n)
        (bus_valid && data_kind == IYR_K_STACK && $past(data_kind)
            != IYR_K_STACK) |=> (addr == $past(addr) - 16'h0001 && !rw);
    endproperty
    a_stack_pair: assert property (p_stack_pair)
        else $error("stacking order wrong");

    property p_sp_drop;
        @(posedge clk) disable iff (!reset_n)
        (bus_valid && data_kind == IYR_K_STACK && cycle_num ==
            cycles_of(grp_r)) |=> (stack_ptr == $past(addr) - 16'h0001);
    endproperty
    a_sp_drop: assert property (p_sp_drop)
        else $error("stack pointer not lowered by two");

    property p_rmw_len;
        @(posedge clk) disable iff (!reset_n)
        (bus_valid && grp_r == IYR_G_RMW && !rw) |-> cycle_num == 4'h7;
    endproperty
    a_rmw_len: assert property (p_rmw_len)
        else $error("write back not in cycle seven");

    c_jsr: cover property (@(posedge clk) disable iff (!reset_n)
        bus_valid && grp_r == IYR_G_JSR && cycle_num == 4'h7);
    c_bsr: cover property (@(posedge clk) disable iff (!reset_n)
        bus_valid && grp_r == IYR_G_BSR && cycle_num == 4'h6);
    c_bit: cover property (@(posedge clk) disable iff (!reset_n)
        bus_valid && grp_r == IYR_G_BIT && !rw);
endmodule // iyr_sequencer
`default_nettype wire

/* File: testbench/iyr_memory.sv */
// Behavioural memory and a noise source on the sequencer's bus.
// Assumes reads are answered combinationally in the cycle they show.
`timescale 1ns/1ps
`default_nettype none
module iyr_memory
    import iyr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bus
    input wire logic [15:0] addr,
    input wire logic rw,
    input wire logic [7:0] wr_data,
    input wire logic bus_valid,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:65535];
    logic [7:0] noise_r;

    // Changing pattern, so nothing can lean on dummy or idle reads
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            noise_r <= 8'h5A;
        end else begin
            noise_r <= noise_r + 8'h3B;
        end
    end

    // Plain always: the bench also preloads this array
    always @(posedge clk) begin
        if (bus_valid && !rw) begin
            mem[addr] <= wr_data;
        end
    end

    always_comb begin
        if (bus_valid && rw && addr != IYR_DUMMY_ADDR) begin
            rd_data = mem[addr];
        end else begin
            rd_data = noise_r;
        end
    end
endmodule // iyr_memory
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the Y-indexed and relative bus sequencer.
// Assumes the memory model answers reads in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import iyr_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n, start, load_y, rw, bus_valid, busy, done;
    iyr_group_e group;
    iyr_kind_e data_kind;
    logic [15:0] opcode_addr, store_data, addr, index_y_register, stack_ptr;
    logic [15:0] eff_addr, operand, exp_y, exp_sp;
    logic [7:0] modify_data, acc_data, rd_data, wr_data, mask_byte;
    logic [7:0] branch_offset;
    logic [3:0] cycle_num;
    logic [24:0] exp_q[$];
    int mismatches = 0;
    int samples_checked = 0;

    always #25 clk = ~clk;

    iyr_sequencer iyr_sequencer_i (.clk(clk), .reset_n(reset_n),
        .start(start), .group(group), .opcode_addr(opcode_addr),
        .modify_data(modify_data), .acc_data(acc_data),
        .store_data(store_data), .load_y(load_y), .rd_data(rd_data),
        .addr(addr), .rw(rw), .wr_data(wr_data), .bus_valid(bus_valid),
        .data_kind(data_kind), .busy(busy), .done(done),
        .cycle_num(cycle_num), .index_y_register(index_y_register),
        .stack_ptr(stack_ptr), .eff_addr(eff_addr), .operand(operand),
        .mask_byte(mask_byte), .branch_offset(branch_offset));

    iyr_memory iyr_memory_i (.clk(clk), .reset_n(reset_n), .addr(addr),
        .rw(rw), .wr_data(wr_data), .bus_valid(bus_valid),
        .rd_data(rd_data));

    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic exr(input logic [15:0] a);
        exp_q.push_back({a, 1'b1, 8'h00});
    endtask

    task automatic exw(input logic [15:0] a, input logic [7:0] d);
        exp_q.push_back({a, 1'b0, d});
    endtask

    // Starts one instruction and judges every bus cycle against exp_q
    task automatic run(input iyr_group_e g, input logic [15:0] p,
                       input bit poke);
        logic [24:0] e;
        int i;
        @(negedge clk);
        group = g;
        opcode_addr = p;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        i = 0;
        while (bus_valid !== 1'b1 && i < 4) begin
            @(negedge clk);
            i++;
        end
        i = 0;
        while (bus_valid === 1'b1 && i < 12) begin
            i++;
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h0;
            chk("cycle", {12'h0, cycle_num}, 16'(i));
            chk("addr", addr, e[24:9]);
            chk("rw", {15'h0, rw}, {15'h0, e[8]});
            if (e[8] == 1'b0) begin
                chk("wr_data", {8'h0, wr_data}, {8'h0, e[7:0]});
            end
            if (i == 1) begin
                chk("kind", {13'h0, data_kind}, {13'h0, IYR_K_OPCODE});
            end else if (e[24:9] == IYR_DUMMY_ADDR) begin
                chk("kind", {13'h0, data_kind}, {13'h0, IYR_K_DUMMY});
            end
            chk("busy", {15'h0, busy}, {15'h0, exp_q.size() > 0});
            // A second request while busy must be ignored
            if (poke && i == 2) begin
                start = 1'b1;
                group = IYR_G_JMP;
            end
            if (poke && i == 3) begin
                start = 1'b0;
            end
            @(negedge clk);
        end
        chk("left", 16'(exp_q.size()), 16'h0);
        chk("done", {15'h0, done}, 16'h1);
    endtask

    task automatic go(input iyr_group_e g, input logic [15:0] p,
                      input logic [7:0] off, input logic [15:0] w,
                      input bit poke);
        logic [15:0] ea;
        logic [15:0] ret;
        ea = exp_y + {8'h00, off};
        if (g == IYR_G_BR || g == IYR_G_BSR) begin
            iyr_memory_i.mem[p] = 8'h20;
            iyr_memory_i.mem[p + 16'h1] = off;
            exr(p);
            exr(p + 16'h1);
            exr(IYR_DUMMY_ADDR);
            ret = p + 16'h2;
        end else begin
            iyr_memory_i.mem[p] = IYR_PREBYTE;
            iyr_memory_i.mem[p + 16'h1] = 8'hA6;
            iyr_memory_i.mem[p + 16'h2] = off;
            iyr_memory_i.mem[p + 16'h3] = 8'h81;
            iyr_memory_i.mem[p + 16'h4] = 8'hF6;
            iyr_memory_i.mem[ea] = w[15:8];
            iyr_memory_i.mem[ea + 16'h1] = w[7:0];
            exr(p);
            exr(p + 16'h1);
            exr(p + 16'h2);
            exr(IYR_DUMMY_ADDR);
            ret = p + 16'h3;
        end
        case (g)
            IYR_G_RD8: exr(ea);
            IYR_G_RMW: begin
                exr(ea);
                exr(IYR_DUMMY_ADDR);
                exw(ea, modify_data);
            end
            IYR_G_TST: begin
                exr(ea);
                exr(IYR_DUMMY_ADDR);
                exr(IYR_DUMMY_ADDR);
            end
            IYR_G_ST8: exw(ea, acc_data);
            IYR_G_LD16, IYR_G_AR16: begin
                exr(ea);
                exr(ea + 16'h1);
                if (g == IYR_G_AR16) exr(IYR_DUMMY_ADDR);
            end
            IYR_G_ST16: begin
                exw(ea, store_data[15:8]);
                exw(ea + 16'h1, store_data[7:0]);
            end
            IYR_G_BIT, IYR_G_BRB: begin
                exr(ea);
                exr(p + 16'h3);
                if (g == IYR_G_BRB) exr(p + 16'h4);
                exr(IYR_DUMMY_ADDR);
                if (g == IYR_G_BIT) exw(ea, modify_data);
            end
            IYR_G_JSR, IYR_G_BSR: begin
                exr(g == IYR_G_JSR ? ea : ret + {{8{off[7]}}, off});
                exw(exp_sp, ret[7:0]);
                exw(exp_sp - 16'h1, ret[15:8]);
                exp_sp = exp_sp - 16'h2;
            end
            default: ;
        endcase
        run(g, p, poke);
        if (g == IYR_G_LD16 && load_y) exp_y = w;
        chk("stack_ptr", stack_ptr, exp_sp);
        chk("index_y", index_y_register, exp_y);
        if (g != IYR_G_BR && g != IYR_G_BSR && g != IYR_G_JMP) begin
            chk("eff_addr", eff_addr, ea);
        end
        if (g == IYR_G_LD16 || g == IYR_G_AR16) begin
            chk("operand", operand, w);
        end
        if (g == IYR_G_BIT || g == IYR_G_BRB) begin
            chk("mask", {8'h0, mask_byte}, 16'h0081);
        end
        if (g == IYR_G_BRB) begin
            chk("boff", {8'h0, branch_offset}, 16'h00F6);
        end
    endtask

    task automatic s_reset();
        reset_n = 1'b0;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        chk("reset sp", stack_ptr, IYR_RESET_SP);
    endtask

    // Loads Y, so later offsets carry across the low byte
    task automatic s_load_y();
        load_y = 1'b1;
        go(IYR_G_LD16, 16'h0100, 8'h10, 16'h20F0, 1'b0);
        load_y = 1'b0;
    endtask

    task automatic s_y_groups();
        acc_data = 8'h3C;
        store_data = 16'hC3A5;
        modify_data = 8'h96;
        go(IYR_G_JMP, 16'h0200, 8'hF0, 16'h0000, 1'b0);
        go(IYR_G_RD8, 16'h0210, 8'h00, 16'h4400, 1'b0);
        go(IYR_G_TST, 16'h0220, 8'hF0, 16'h7100, 1'b0);
        go(IYR_G_ST8, 16'h0230, 8'hF0, 16'h0000, 1'b0);
        go(IYR_G_LD16, 16'h0240, 8'hFF, 16'h1357, 1'b0);
        go(IYR_G_ST16, 16'h0250, 8'hF0, 16'h0000, 1'b0);
        go(IYR_G_AR16, 16'h0260, 8'h80, 16'h7E01, 1'b0);
        go(IYR_G_RMW, 16'h0270, 8'hF0, 16'h2200, 1'b0);
        go(IYR_G_BIT, 16'h0280, 8'h7F, 16'h5500, 1'b0);
        go(IYR_G_BRB, 16'h0290, 8'hF0, 16'h0F00, 1'b0);
        go(IYR_G_JSR, 16'h02A0, 8'h01, 16'h0000, 1'b0);
    endtask

    task automatic s_relative();
        go(IYR_G_BR, 16'h0300, 8'h05, 16'h0000, 1'b0);
        go(IYR_G_BR, 16'h0310, 8'h80, 16'h0000, 1'b0);
        go(IYR_G_BSR, 16'h0320, 8'hF0, 16'h0000, 1'b0);
    endtask

    task automatic s_refuse();
        go(IYR_G_JSR, 16'h0400, 8'h02, 16'h0000, 1'b1);
        repeat (3) @(negedge clk);
        chk("no extra", {15'h0, bus_valid}, 16'h0);
    endtask

    // Reset in the middle of a call must abandon it cleanly
    task automatic s_mid_reset();
        group = IYR_G_JSR;
        opcode_addr = 16'h0500;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (4) @(negedge clk);
        reset_n = 1'b0;
        @(negedge clk);
        chk("rst addr", addr, IYR_DUMMY_ADDR);
        reset_n = 1'b1;
        exp_sp = IYR_RESET_SP;
        exp_y = IYR_RESET_IY;
        chk("rst sp", stack_ptr, exp_sp);
        go(IYR_G_BR, 16'h0510, 8'h02, 16'h0000, 1'b0);
    endtask

    initial begin
        reset_n = 1'b0;
        start = 1'b0;
        group = IYR_G_JMP;
        opcode_addr = 16'h0000;
        modify_data = 8'h00;
        acc_data = 8'h00;
        store_data = 16'h0000;
        load_y = 1'b0;
        exp_y = IYR_RESET_IY;
        exp_sp = IYR_RESET_SP;
        s_reset();
        s_load_y();
        s_y_groups();
        s_relative();
        s_refuse();
        s_mid_reset();
        end_sim();
    end

    // About twenty short instructions; far below this span
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule // testbench
`default_nettype wire
